// ==== rtl/touch_consts.svh ====
`ifndef TOUCH_CONSTS_SVH
`define TOUCH_CONSTS_SVH
// ****************
// Register offsets
// ****************
`define OFS_FIRST_CONFIG 8'h00
`define OFS_CONTROL 8'h04
`define OFS_STATUS 8'h08
`define OFS_IRQ_STATUS 8'h0C
`define OFS_IRQ_CLEAR 8'h10
`define OFS_IRQ_ENABLE 8'h14
// ****************
// Field positions
// ****************
`define CFG_DIV_LO 0
`define CFG_RES12 2
`define CFG_SETTLE_LO 3
`define CFG_PRE_LO 6
`define CFG_SENSE_LO 9
`define CFG_NOTIFY_PEN 12
`define CFG_WIDTH 13
`define CTL_START 0
`define CTL_SOFT_RESET 1
`define EV_DONE 0
`define EV_PEN 1
`define EV_CFG_ERR 2
`define EV_WIDTH 3
// ****************
// Reset values
// ****************
`define CFG_RESET 13'h0002
`define IRQ_EN_RESET 3'h0
// ****************
// Timing
// ****************
`define CLK_HZ 50000000
`define OSC_HZ 4000000
`define OSC_DIV ((`CLK_HZ + `OSC_HZ / 2) / `OSC_HZ)
`define HW_RST_MIN_NS 10000
`define HW_RST_CYC ((`HW_RST_MIN_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define DELAY_STEP_TICKS 16
`define SAMPLES_PER_CONV 3
`endif

// ==== rtl/touch_pkg.sv ====
package touch_pkg;
    typedef enum logic [1:0] {
        DIV_BY_1,
        DIV_BY_2,
        DIV_BY_4,
        DIV_RSVD
    } conv_div_t;
    typedef enum logic [1:0] {
        SET_Y,
        SET_X,
        SET_Z
    } meas_set_t;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETTLE,
        ST_CONVERT,
        ST_PRECHARGE,
        ST_SENSE
    } seq_state_t;
endpackage : touch_pkg

// ==== rtl/conv_clk_if.sv ====
`timescale 1ns/1ps
interface conv_clk_if;
    logic osc_tick;
    touch_pkg::conv_div_t div_code;
    logic conv_tick;
    modport ctrl (output osc_tick, output div_code, input conv_tick);
    modport div (input osc_tick, input div_code, output conv_tick);
endinterface : conv_clk_if

// ==== rtl/conv_clk_divider.sv ====
`timescale 1ns/1ps
`include "touch_consts.svh"
module conv_clk_divider (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Oscillator side
    conv_clk_if.div cif
);
    logic [1:0] cnt_r;
    logic [1:0] last_r;

    // ****************
    // Integer division
    // ****************
    function automatic logic [1:0] last_count(input touch_pkg::conv_div_t code);
        case (code)
            touch_pkg::DIV_BY_1: last_count = 2'h0;
            touch_pkg::DIV_BY_2: last_count = 2'h1;
            default: last_count = 2'h3;
        endcase
    endfunction : last_count

    always_comb begin
        last_r = last_count(cif.div_code);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= 2'h0;
            cif.conv_tick <= 1'b0;
        end else if (ce_i) begin
            cif.conv_tick <= 1'b0;
            if (cif.osc_tick) begin
                if (cnt_r >= last_r) begin
                    cnt_r <= 2'h0;
                    cif.conv_tick <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 2'h1;
                end
            end
        end
    end
endmodule : conv_clk_divider

// ==== rtl/touch_conversion_clock_control.sv ====
`timescale 1ns/1ps
`include "touch_consts.svh"
// Functional notes
// - Notify pin shows data-available or pen-down, chosen by config bit.
// - Hardware reset pin is active low and restores default state.
// - Two address-select pins form target address bits 0 and 1.
// - State machines run from 4 MHz oscillator; converter clock divides it.
// - Divide-by-one is accurate only at 10-bit resolution.
// - 12-bit needs divide-by-two or divide-by-four.
// - Two-bit field of first config register picks the divide ratio.
// - X set: plus, minus and layer-current conversions.
// - Y set: plus, minus and layer-current conversions.
// - Pressure set: two conversions, first and second sample.
// - Per set: drive panel, wait settle, three samples; Y, X, pressure.
// - Reset pulse of 10 us accepted, short pulses and spikes ignored.
// - Soft reset bit 1 of control word restores default state.
module touch_conversion_clock_control #(
    parameter int HW_RST_CYC = `HW_RST_CYC
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Device pins
    input wire logic reset_pin_n_i,
    input wire logic addr_sel_low_i,
    input wire logic addr_sel_high_i,
    input wire logic pen_touch_i,
    output logic touch_notify_out_n_o,
    output logic [1:0] target_addr_lo_o,
    // Panel, converter and interrupt
    output logic [3:0] panel_drv_o,
    output logic [2:0] conv_sel_o,
    output logic sample_o,
    output logic res12_o,
    output logic irq_o
);
    // ****************
    // Declarations
    // ****************
    conv_clk_if cif ();
    logic [3:0] osc_cnt_r;
    logic [`CFG_WIDTH-1:0] cfg_r;
    logic [`EV_WIDTH-1:0] irq_stat_r;
    logic [`EV_WIDTH-1:0] irq_en_r;
    logic [`EV_WIDTH-1:0] ev_set;
    logic [2:0] rst_sync_r;
    logic rst_filt_r;
    logic [15:0] rst_low_cnt_r;
    logic hw_rst_r;
    logic sw_rst_r;
    logic srst;
    logic [2:0] a0_sync_r;
    logic [2:0] a1_sync_r;
    logic [2:0] pen_sync_r;
    logic pen_r;
    logic pen_prev_r;
    logic wr_en;
    logic rd_en;
    logic start_r;
    logic data_avail_r;
    touch_pkg::seq_state_t state_r;
    touch_pkg::meas_set_t set_r;
    logic [1:0] conv_idx_r;
    logic [1:0] smp_idx_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] wait_r;
    logic res12_eff;
    logic last_conv;

    // ****************
    // Reset sources
    // ****************
    assign srst = rst_i | hw_rst_r | sw_rst_r;

    // Three flops; a level change counts once the last two agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_sync_r <= 3'h7;
            rst_filt_r <= 1'b1;
        end else if (ce_i) begin
            rst_sync_r <= {rst_sync_r[1:0], reset_pin_n_i};
            if (rst_sync_r[1] == rst_sync_r[2]) begin
                rst_filt_r <= rst_sync_r[2];
            end
        end
    end

    // Pulse shorter than the minimum is dropped; one reset per pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_low_cnt_r <= 16'h0000;
            hw_rst_r <= 1'b0;
        end else if (ce_i) begin
            hw_rst_r <= 1'b0;
            if (rst_filt_r) begin
                rst_low_cnt_r <= 16'h0000;
            end else if (rst_low_cnt_r != 16'(HW_RST_CYC)) begin
                rst_low_cnt_r <= rst_low_cnt_r + 16'h0001;
                if (rst_low_cnt_r == 16'(HW_RST_CYC - 1)) begin
                    hw_rst_r <= 1'b1;
                end
            end
        end
    end

    // ****************
    // Pin synchronisers
    // ****************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a0_sync_r <= 3'h0;
            a1_sync_r <= 3'h0;
            pen_sync_r <= 3'h0;
            target_addr_lo_o <= 2'h0;
            pen_r <= 1'b0;
        end else if (ce_i) begin
            a0_sync_r <= {a0_sync_r[1:0], addr_sel_low_i};
            a1_sync_r <= {a1_sync_r[1:0], addr_sel_high_i};
            pen_sync_r <= {pen_sync_r[1:0], pen_touch_i};
            if (a0_sync_r[1] == a0_sync_r[2]) begin
                target_addr_lo_o[0] <= a0_sync_r[2];
            end
            if (a1_sync_r[1] == a1_sync_r[2]) begin
                target_addr_lo_o[1] <= a1_sync_r[2];
            end
            if (pen_sync_r[1] == pen_sync_r[2]) begin
                pen_r <= pen_sync_r[2];
            end
        end
    end

    // ****************
    // Oscillator and divider
    // ****************
    // Nominal oscillator rate; exact 4 MHz is not reachable from this clock
    always_ff @(posedge clk_i) begin
        if (srst) begin
            osc_cnt_r <= 4'h0;
            cif.osc_tick <= 1'b0;
        end else if (ce_i) begin
            cif.osc_tick <= (osc_cnt_r == 4'(`OSC_DIV - 1));
            if (osc_cnt_r == 4'(`OSC_DIV - 1)) begin
                osc_cnt_r <= 4'h0;
            end else begin
                osc_cnt_r <= osc_cnt_r + 4'h1;
            end
        end
    end

    assign cif.div_code = touch_pkg::conv_div_t'(cfg_r[`CFG_DIV_LO +: 2]);

    conv_clk_divider u_div (
        .clk_i(clk_i),
        .rst_i(srst),
        .ce_i(ce_i),
        .cif(cif)
    );

    // Full speed forces 10-bit, since 12-bit results would be wrong
    assign res12_eff = cfg_r[`CFG_RES12] && (cif.div_code != touch_pkg::DIV_BY_1);

    // ****************
    // Register bus
    // ****************
    // Writes land at the ack edge, while the master still holds the request
    assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    assign rd_en = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else if (ce_i) begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst) begin
            cfg_r <= `CFG_WIDTH'(`CFG_RESET);
            irq_en_r <= `EV_WIDTH'(`IRQ_EN_RESET);
        end else if (ce_i && wr_en) begin
            if (wb_adr_i == `OFS_FIRST_CONFIG) begin
                if (wb_sel_i[0]) cfg_r[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) cfg_r[12:8] <= wb_dat_i[12:8];
            end
            if (wb_adr_i == `OFS_IRQ_ENABLE && wb_sel_i[0]) begin
                irq_en_r <= wb_dat_i[`EV_WIDTH-1:0];
            end
        end
    end

    // Control word is write-only; its bits act as one-cycle pulses
    always_ff @(posedge clk_i) begin
        if (srst) begin
            start_r <= 1'b0;
            sw_rst_r <= 1'b0;
        end else if (ce_i) begin
            start_r <= wr_en && wb_adr_i == `OFS_CONTROL && wb_sel_i[0]
                && wb_dat_i[`CTL_START];
            sw_rst_r <= wr_en && wb_adr_i == `OFS_CONTROL && wb_sel_i[0]
                && wb_dat_i[`CTL_SOFT_RESET];
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_dat_o <= 32'h0000_0000;
            if (rd_en) begin
                case (wb_adr_i)
                    `OFS_FIRST_CONFIG: wb_dat_o <= 32'(cfg_r);
                    `OFS_STATUS: wb_dat_o <= {26'h0, res12_eff, pen_r,
                        target_addr_lo_o, data_avail_r, state_r != touch_pkg::ST_IDLE};
                    `OFS_IRQ_STATUS: wb_dat_o <= 32'(irq_stat_r);
                    `OFS_IRQ_ENABLE: wb_dat_o <= 32'(irq_en_r);
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ****************
    // Interrupts
    // ****************
    always_ff @(posedge clk_i) begin
        if (srst) begin
            pen_prev_r <= 1'b0;
        end else if (ce_i) begin
            pen_prev_r <= pen_r;
        end
    end

    always_comb begin
        ev_set = '0;
        ev_set[`EV_DONE] = (state_r == touch_pkg::ST_CONVERT) && last_conv;
        ev_set[`EV_PEN] = pen_r & ~pen_prev_r;
        ev_set[`EV_CFG_ERR] = start_r && cfg_r[`CFG_RES12] && !res12_eff;
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (srst) begin
            irq_stat_r <= '0;
        end else if (ce_i) begin
            if (wr_en && wb_adr_i == `OFS_IRQ_CLEAR && wb_sel_i[0]) begin
                irq_stat_r <= (irq_stat_r & ~wb_dat_i[`EV_WIDTH-1:0]) | ev_set;
            end else begin
                irq_stat_r <= irq_stat_r | ev_set;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst) begin
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_o <= |(irq_stat_r & irq_en_r);
        end
    end

    // Data-available flag drops when software clears the done event
    always_ff @(posedge clk_i) begin
        if (srst) begin
            data_avail_r <= 1'b0;
        end else if (ce_i) begin
            if (ev_set[`EV_DONE]) begin
                data_avail_r <= 1'b1;
            end else if (wr_en && wb_adr_i == `OFS_IRQ_CLEAR && wb_dat_i[`EV_DONE]) begin
                data_avail_r <= 1'b0;
            end
        end
    end

    // Host input must float-free; the pin is driven at both levels
    always_ff @(posedge clk_i) begin
        if (srst) begin
            touch_notify_out_n_o <= 1'b1;
        end else if (ce_i) begin
            touch_notify_out_n_o <= cfg_r[`CFG_NOTIFY_PEN] ? ~pen_r : ~data_avail_r;
        end
    end

    // ****************
    // Measurement sequencer
    // ****************
    function automatic logic [7:0] delay_ticks(input logic [2:0] code);
        delay_ticks = 8'(code * `DELAY_STEP_TICKS);
    endfunction : delay_ticks

    function automatic logic [1:0] last_conv_idx(input touch_pkg::meas_set_t s);
        last_conv_idx = (s == touch_pkg::SET_Z) ? 2'h1 : 2'h2;
    endfunction : last_conv_idx

    assign last_conv = cif.conv_tick && bit_cnt_r == 4'h0
        && smp_idx_r == 2'(`SAMPLES_PER_CONV - 1)
        && conv_idx_r == last_conv_idx(touch_pkg::SET_Z) && set_r == touch_pkg::SET_Z;

    always_ff @(posedge clk_i) begin
        if (srst) begin
            state_r <= touch_pkg::ST_IDLE;
            set_r <= touch_pkg::SET_Y;
            conv_idx_r <= 2'h0;
            smp_idx_r <= 2'h0;
            bit_cnt_r <= 4'h0;
            wait_r <= 8'h00;
        end else if (ce_i) begin
            case (state_r)
                touch_pkg::ST_IDLE: begin
                    if (start_r) begin
                        set_r <= touch_pkg::SET_Y;
                        conv_idx_r <= 2'h0;
                        smp_idx_r <= 2'h0;
                        wait_r <= delay_ticks(cfg_r[`CFG_SETTLE_LO +: 3]);
                        state_r <= touch_pkg::ST_SETTLE;
                    end
                end
                touch_pkg::ST_SETTLE: begin
                    if (wait_r == 8'h00) begin
                        bit_cnt_r <= res12_eff ? 4'hB : 4'h9;
                        state_r <= touch_pkg::ST_CONVERT;
                    end else if (cif.osc_tick) begin
                        wait_r <= wait_r - 8'h01;
                    end
                end
                touch_pkg::ST_CONVERT: begin
                    if (cif.conv_tick) begin
                        if (bit_cnt_r != 4'h0) begin
                            bit_cnt_r <= bit_cnt_r - 4'h1;
                        end else if (smp_idx_r != 2'(`SAMPLES_PER_CONV - 1)) begin
                            smp_idx_r <= smp_idx_r + 2'h1;
                            bit_cnt_r <= res12_eff ? 4'hB : 4'h9;
                        end else if (conv_idx_r != last_conv_idx(set_r)) begin
                            smp_idx_r <= 2'h0;
                            conv_idx_r <= conv_idx_r + 2'h1;
                            bit_cnt_r <= res12_eff ? 4'hB : 4'h9;
                        end else if (set_r == touch_pkg::SET_Z) begin
                            state_r <= touch_pkg::ST_IDLE;
                        end else begin
                            wait_r <= delay_ticks(cfg_r[`CFG_PRE_LO +: 3]);
                            state_r <= touch_pkg::ST_PRECHARGE;
                        end
                    end
                end
                touch_pkg::ST_PRECHARGE: begin
                    if (wait_r == 8'h00) begin
                        wait_r <= delay_ticks(cfg_r[`CFG_SENSE_LO +: 3]);
                        state_r <= touch_pkg::ST_SENSE;
                    end else if (cif.osc_tick) begin
                        wait_r <= wait_r - 8'h01;
                    end
                end
                touch_pkg::ST_SENSE: begin
                    if (wait_r == 8'h00) begin
                        set_r <= (set_r == touch_pkg::SET_Y) ? touch_pkg::SET_X
                            : touch_pkg::SET_Z;
                        conv_idx_r <= 2'h0;
                        smp_idx_r <= 2'h0;
                        wait_r <= delay_ticks(cfg_r[`CFG_SETTLE_LO +: 3]);
                        state_r <= touch_pkg::ST_SETTLE;
                    end else if (cif.osc_tick) begin
                        wait_r <= wait_r - 8'h01;
                    end
                end
                default: state_r <= touch_pkg::ST_IDLE;
            endcase
        end
    end

    // ****************
    // Panel drive outputs
    // ****************
    // Drivers: {y_minus, y_plus, x_minus, x_plus}; off between sets
    always_ff @(posedge clk_i) begin
        if (srst) begin
            panel_drv_o <= 4'h0;
            conv_sel_o <= 3'h0;
            sample_o <= 1'b0;
            res12_o <= 1'b0;
        end else if (ce_i) begin
            res12_o <= res12_eff;
            sample_o <= state_r == touch_pkg::ST_CONVERT && cif.conv_tick && bit_cnt_r == 4'h0;
            if (state_r == touch_pkg::ST_SETTLE || state_r == touch_pkg::ST_CONVERT) begin
                case (set_r)
                    touch_pkg::SET_Y: panel_drv_o <= 4'hC;
                    touch_pkg::SET_X: panel_drv_o <= 4'h3;
                    default: panel_drv_o <= 4'h6;
                endcase
                // 0-2 vertical, 3-5 horizontal, 6-7 pressure
                case (set_r)
                    touch_pkg::SET_Y: conv_sel_o <= {1'b0, conv_idx_r};
                    touch_pkg::SET_X: conv_sel_o <= 3'h3 + {1'b0, conv_idx_r};
                    default: conv_sel_o <= 3'h6 + {1'b0, conv_idx_r};
                endcase
            end else begin
                panel_drv_o <= 4'h0;
            end
        end
    end
endmodule : touch_conversion_clock_control

// ==== test/touch_ctl_properties.sv ====
`timescale 1ns/1ps
module touch_ctl_checker (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Pins and panel
    input wire logic reset_pin_n_i,
    input wire logic addr_sel_low_i,
    input wire logic addr_sel_high_i,
    input wire logic [1:0] target_addr_lo_o,
    input wire logic [3:0] panel_drv_o,
    input wire logic [2:0] conv_sel_o,
    input wire logic sample_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ****************
    // Sequences
    // ****************
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
    endsequence
    // Address pins steady long enough to pass the filter
    sequence s_pins_held;
        ($stable({addr_sel_high_i, addr_sel_low_i}) && reset_pin_n_i)[*8];
    endsequence
    // ****************
    // Properties
    // ****************
    property p_ack_next; s_req |=> wb_ack_o; endproperty
    property p_ack_pulse; wb_ack_o && ce_i |=> !wb_ack_o; endproperty
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    property p_addr; s_pins_held |-> target_addr_lo_o == {addr_sel_high_i, addr_sel_low_i}; endproperty
    property p_sample_gap; sample_o |=> !sample_o [*8]; endproperty
    property p_ydrv; sample_o && conv_sel_o <= 3'h2 |-> panel_drv_o == 4'hC; endproperty
    property p_xdrv; sample_o && conv_sel_o inside {[3'h3:3'h5]} |-> panel_drv_o == 4'h3; endproperty
    property p_zdrv; sample_o && conv_sel_o >= 3'h6 |-> panel_drv_o == 4'h6; endproperty
    property p_order;
        $changed(conv_sel_o) |-> conv_sel_o == $past(conv_sel_o) + 3'h1 || conv_sel_o == 3'h0;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    a_addr: assert property (p_addr) else $error("target address differs from pins");
    a_sample_gap: assert property (p_sample_gap) else $error("samples too close");
    a_ydrv: assert property (p_ydrv) else $error("wrong drivers in vertical set");
    a_xdrv: assert property (p_xdrv) else $error("wrong drivers in horizontal set");
    a_zdrv: assert property (p_zdrv) else $error("wrong drivers in pressure set");
    a_order: assert property (p_order) else $error("conversion order broken");
endmodule : touch_ctl_checker

bind touch_conversion_clock_control touch_ctl_checker u_touch_ctl_checker (
    .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .reset_pin_n_i,
    .addr_sel_low_i, .addr_sel_high_i, .target_addr_lo_o, .panel_drv_o, .conv_sel_o, .sample_o
);

// ==== test/host_pin_model.sv ====
`timescale 1ns/1ps
module host_pin_model #(
    parameter int PWR_CYC = 30
) (
    // Clock
    input wire logic clk_i,
    // Device pins
    input wire logic notify_n_i,
    output logic reset_pin_n_o
);
    // Notify is a plain input here, no pull level of our own
    // Power-up: pin low until supplies settle, then margin
    initial begin
        reset_pin_n_o = 1'b0;
        repeat (PWR_CYC) @(posedge clk_i);
        reset_pin_n_o <= 1'b1;
    end
    task automatic pulse(input int len);
        reset_pin_n_o <= 1'b0;
        repeat (len) @(posedge clk_i);
        reset_pin_n_o <= 1'b1;
    endtask : pulse
endmodule : host_pin_model

// ==== test/touch_conversion_clock_control_tb.sv ====
`timescale 1ns/1ps
module touch_conversion_clock_control_tb;
    // Shortened so the pin reset cases stay brief
    localparam int RST_CYC = 20;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic reset_pin_n_i;
    logic addr_sel_low_i = 1'b0;
    logic addr_sel_high_i = 1'b0;
    logic pen_touch_i = 1'b0;
    logic touch_notify_out_n_o;
    logic [1:0] target_addr_lo_o;
    logic [3:0] panel_drv_o;
    logic [2:0] conv_sel_o;
    logic sample_o;
    logic res12_o;
    logic irq_o;
    int num_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    int t0;
    int per[4];
    logic [31:0] rd;
    logic [2:0] sel_q[$];

    always #10 clk_i = ~clk_i;

    touch_conversion_clock_control #(.HW_RST_CYC(RST_CYC)) u_touch_conversion_clock_control (
        .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .reset_pin_n_i, .addr_sel_low_i, .addr_sel_high_i,
        .pen_touch_i, .touch_notify_out_n_o, .target_addr_lo_o, .panel_drv_o, .conv_sel_o,
        .sample_o, .res12_o, .irq_o
    );
    host_pin_model #(.PWR_CYC(RST_CYC + 30)) u_host_pin_model (
        .clk_i, .notify_n_i(touch_notify_out_n_o), .reset_pin_n_o(reset_pin_n_i)
    );

    // ****************
    // Tasks
    // ****************
    task automatic end_sim();
        $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    // Cut a hang short
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            num_errors++;
            end_sim();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic wait_sample();
        do @(posedge clk_i); while (sample_o !== 1'b1);
    endtask : wait_sample

    // ****************
    // Main sequence
    // ****************
    initial begin
        void'($urandom(32'h47B8));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (40) @(posedge clk_i);
        wb(0, 8'h00, 0);
        chk("config_reset", rd, 32'h2);
        wb(0, 8'h14, 0);
        chk("irq_en_reset", rd, 32'h0);
        wb(0, 8'h20, 0);
        chk("unmapped", rd, 32'h0);
        for (int i = 0; i < 6; i++) begin
            {addr_sel_high_i, addr_sel_low_i} <= 2'($urandom);
            repeat (10) @(posedge clk_i);
            chk("taddr", 32'(target_addr_lo_o), 32'({addr_sel_high_i, addr_sel_low_i}));
        end
        // Each divide code: spacing of two samples, then abort by soft reset
        for (int c = 0; c < 4; c++) begin
            wb(1, 8'h00, 32'(c));
            wb(1, 8'h04, 32'h1);
            wait_sample();
            t0 = cyc;
            wait_sample();
            per[c] = cyc - t0;
            wb(1, 8'h04, 32'h2);
            wb(0, 8'h00, 0);
            chk("config_soft", rd, 32'h2);
            wb(0, 8'h08, 0);
            chk("busy_soft", rd & 32'h1, 32'h0);
        end
        chk("div2", per[1], 2 * per[0]);
        chk("div4", per[2], 4 * per[0]);
        chk("div_rsvd", per[3], per[2]);
        wb(1, 8'h00, 32'h4);
        wb(1, 8'h04, 32'h1);
        wb(0, 8'h0C, 0);
        chk("res_err", rd & 32'h4, 32'h4);
        chk("res_div1", res12_o, 1'b0);
        wb(1, 8'h04, 32'h2);
        wb(1, 8'h00, 32'h5);
        wb(1, 8'h04, 32'h1);
        wb(0, 8'h0C, 0);
        chk("res_div2", res12_o, 1'b1);
        chk("no_res_err", rd & 32'h4, 32'h0);
        wb(1, 8'h04, 32'h2);
        // Full run at the fast clock with settle delays
        wb(1, 8'h14, 32'h1);
        wb(1, 8'h00, {19'h0, 1'b0, 3'($urandom), 3'($urandom), 3'(1 + $urandom % 7), 3'h0});
        wb(1, 8'h04, 32'h1);
        for (int i = 0; i < 24; i++) begin
            wait_sample();
            sel_q.push_back(conv_sel_o);
        end
        for (int i = 0; i < 24; i++) begin
            chk("conv_sel", sel_q[i], 32'(i / 3));
        end
        do wb(0, 8'h08, 0); while (rd[1] !== 1'b1);
        repeat (2) @(posedge clk_i);
        chk("irq_done", irq_o, 1'b1);
        chk("notify_dav", touch_notify_out_n_o, 1'b0);
        wb(1, 8'h10, 32'h1);
        repeat (2) @(posedge clk_i);
        chk("irq_clr", irq_o, 1'b0);
        chk("notify_clr", touch_notify_out_n_o, 1'b1);
        // Pen mode with the interrupt masked, then unmasked and cleared
        wb(1, 8'h14, 32'h0);
        wb(1, 8'h00, 32'h1002);
        pen_touch_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        chk("notify_pen", touch_notify_out_n_o, 1'b0);
        chk("irq_masked", irq_o, 1'b0);
        wb(0, 8'h0C, 0);
        chk("pen_status", rd & 32'h2, 32'h2);
        wb(1, 8'h14, 32'h2);
        repeat (2) @(posedge clk_i);
        chk("irq_pen", irq_o, 1'b1);
        wb(1, 8'h10, 32'h2);
        pen_touch_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        chk("irq_pen_clr", irq_o, 1'b0);
        chk("notify_idle", touch_notify_out_n_o, 1'b1);
        // Enable low: a pen contact must not reach the notify pin
        ce_i <= 1'b0;
        pen_touch_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        chk("ce_freeze", touch_notify_out_n_o, 1'b1);
        ce_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        chk("ce_run", touch_notify_out_n_o, 1'b0);
        pen_touch_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        // Pin reset: short pulse ignored, long pulse restores defaults
        wb(1, 8'h00, 32'h5);
        u_host_pin_model.pulse(RST_CYC / 4);
        repeat (20) @(posedge clk_i);
        wb(0, 8'h00, 0);
        chk("short_pulse", rd, 32'h5);
        u_host_pin_model.pulse(RST_CYC + 10);
        repeat (20) @(posedge clk_i);
        wb(0, 8'h00, 0);
        chk("long_pulse", rd, 32'h2);
        end_sim();
    end
endmodule : touch_conversion_clock_control_tb
